/* File: rtl/rrb_pkg.sv */
/*
 * shared constants of the receive post-alignment block: symbol and word
 * widths, compensation buffer levels and the register map.
 * assumes a 32-bit Avalon-MM slave with byte addresses and word registers.
 */
package rrb_pkg;
    localparam int SYM_W     = 10;
    localparam int WORD_W    = 20;
    localparam int RM_DEPTH  = 20;
    localparam int RM_EMPTY  = 5;
    localparam int RM_LO_WM  = 8;
    localparam int RM_HI_WM  = 14;
    localparam int ADDR_W    = 6;
    localparam int DATA_W    = 32;

    localparam logic [ADDR_W-1:0] OFS_CTRL   = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_RMPAT1 = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_RMPAT2 = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_BOPAT  = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_ALPAT  = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h14;

    localparam int CB_POL     = 0;
    localparam int CB_SWAP    = 1;
    localparam int CB_RM_EN   = 2;
    localparam int CB_B2B     = 3;
    localparam int CB_BO_EN   = 4;
    localparam int CB_TRIG    = 5;
    localparam int BO_PAD_LSB = 16;

    localparam int SB_LOCK    = 0;
    localparam int SB_FULL    = 1;
    localparam int SB_EMPTY   = 2;
    localparam int SB_SHIFT   = 3;
    localparam int SB_SLIP    = 4;
    localparam int SB_CNT     = 16;
endpackage

/* File: rtl/rrb_rx_post_align.sv */
/*
 * receive post-alignment logic: polarity flip, bit-slip word framing,
 * aligner byte swap in double-width builds, clock-compensation buffer with skip insert/delete,
 * and byte ordering with pad insertion, configured over Avalon-MM.
 * assumes raw deserialised words arrive from pins, asynchronous to REF_CLK,
 * and that fabric logic drains the compensation buffer with RD_EN.
 */
`timescale 1ns/1ps
module rrb_rx_post_align #(
    parameter int DOUBLE_WIDTH = 0,
    parameter int CHAN_WIDTH   = 20,
    parameter int RX_AND_TX    = 1,
    parameter int ENC_8B10B    = 1,
    parameter int SLIP_OUT_EN  = 1,
    parameter int DEPTH        = rrb_pkg::RM_DEPTH,
    parameter int EMPTY_LVL    = rrb_pkg::RM_EMPTY,
    parameter int LO_WM        = rrb_pkg::RM_LO_WM,
    parameter int HI_WM        = rrb_pkg::RM_HI_WM
) (
    input  wire logic                          REF_CLK,       // 25 MHz clock
    input  wire logic                          RST,           // async reset, active high
    input  wire logic [rrb_pkg::ADDR_W-1:0]    ADDRESS,       // byte address
    input  wire logic                          READ,          // bus read
    input  wire logic                          WRITE,         // bus write
    input  wire logic [rrb_pkg::DATA_W-1:0]    WRITEDATA,     // bus write data
    output logic      [rrb_pkg::DATA_W-1:0]    READDATA,      // bus read data
    output logic                               WAITREQUEST,   // bus stall
    input  wire logic [rrb_pkg::WORD_W-1:0]    RX_RAW,        // raw deserialised word
    input  wire logic                          RX_RAW_VALID,  // raw word strobe
    input  wire logic                          BITSLIP,       // slip one bit on rise
    input  wire logic                          BO_REQ,        // fabric byte-order request
    input  wire logic                          RD_EN,         // local-side buffer drain
    output logic      [rrb_pkg::WORD_W-1:0]    RX_DATA_OUT,   // parallel receive word
    output logic                               RX_DATA_VALID, // word strobe
    output logic                               RX_LOCK,       // aligner in sync
    output logic      [$clog2(rrb_pkg::WORD_W)-1:0] RX_SLIP_COUNT, // bits slipped
    output logic                               RM_FULL,       // buffer full
    output logic                               RM_EMPTY,      // buffer at empty level
    output logic                               RM_INSERTED,   // skip inserted pulse
    output logic                               RM_DELETED     // skip deleted pulse
);
    localparam int SW = rrb_pkg::SYM_W;
    localparam int WW = rrb_pkg::WORD_W;
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int LW = $clog2(WW);
    localparam bit RM_ALLOWED = (RX_AND_TX != 0) && (ENC_8B10B != 0);
    localparam bit BO_ALLOWED = (DOUBLE_WIDTH != 0) ? (CHAN_WIDTH == 32 || CHAN_WIDTH == 40)
                                                    : (CHAN_WIDTH == 16 || CHAN_WIDTH == 20);

    if (DEPTH < 2 || EMPTY_LVL >= LO_WM || LO_WM >= HI_WM || HI_WM >= DEPTH) begin : g_bad_levels
        $error("compensation buffer levels out of order");
    end

    typedef struct packed {
        logic [WW-1:0]             s1_data;
        logic [WW-1:0]             s2_data;
        logic                      s1_v;
        logic                      s2_v;
        logic [WW-1:0]             raw_prev;
        logic [WW-1:0]             aw;
        logic                      aw_v;
        logic [LW-1:0]             slip;
        logic                      slip_prev;
        logic                      lock;
        logic [DEPTH-1:0][WW-1:0]  mem;
        logic [PW-1:0]             wp;
        logic [PW-1:0]             rp;
        logic [CW-1:0]             cnt;
        logic                      del_last;
        logic                      ins_last;
        logic                      trig_prev;
        logic                      bo_arm;
        logic                      shift;
        logic [SW-1:0]             held;
        logic [5:0]                ctrl;
        logic [WW-1:0]             pat1;
        logic [WW-1:0]             pat2;
        logic [SW-1:0]             bo_pat;
        logic [SW-1:0]             bo_pad;
        logic [SW-1:0]             al_pat;
        logic [WW-1:0]             out_data;
        logic                      out_v;
        logic                      full;
        logic                      empty;
        logic                      ins;
        logic                      del;
        logic                      waitreq;
        logic [rrb_pkg::DATA_W-1:0] rdata;
    } rrb_state_s;

    rrb_state_s q;
    rrb_state_s n;

    // a compensation word is the control group in the low symbol followed by the skip group
    function automatic logic is_skip(input logic [WW-1:0] w, input logic [WW-1:0] p1,
                                     input logic [WW-1:0] p2);
        is_skip = (w == p1) || (w == p2);
    endfunction

    logic [WW-1:0]   raw;
    logic [2*WW-1:0] cat;
    logic [WW-1:0]   sw_word;
    logic [WW-1:0]   rd_word;
    logic [WW-1:0]   bw;
    logic            bv;
    logic            rm_on;
    logic            bo_on;
    logic            b2b;
    logic            wr_pat;
    logic            rd_pat;
    logic            do_del;
    logic            do_wr;
    logic            do_rd;
    logic            do_ins;
    logic            pop;
    logic            trig;
    logic            rise;
    logic [SW-1:0]   lo_eff;

    always_comb
    begin
        n = q;
        n.s1_data = RX_RAW;
        n.s1_v = RX_RAW_VALID;
        n.s2_data = q.s1_data;
        n.s2_v = q.s1_v;

        raw = q.s2_data ^ {WW{q.ctrl[rrb_pkg::CB_POL]}};
        cat = {raw, q.raw_prev};
        n.aw_v = q.s2_v;
        if (q.s2_v)
        begin
            n.raw_prev = raw;
            n.aw = cat[q.slip +: WW];
        end
        n.slip_prev = BITSLIP;
        if (BITSLIP && !q.slip_prev)
        begin
            n.slip = (q.slip == LW'(WW - 1)) ? '0 : q.slip + 1'b1;
            n.lock = 1'b0;
        end
        // the word after a slip was framed on the old boundary, so it must not relock
        else if (q.aw_v && !q.slip_prev && q.aw[SW-1:0] == q.al_pat)
        begin
            n.lock = 1'b1;
        end

        // the swap control bit is stored and read back but has no effect in single-width builds
        if (DOUBLE_WIDTH != 0 && q.ctrl[rrb_pkg::CB_SWAP])
            sw_word = {q.aw[SW-1:0], q.aw[WW-1:SW]};
        else
            sw_word = q.aw;

        // watermarks sit far from both ends so +-300 ppm drift never reaches them
        rm_on = RM_ALLOWED && q.ctrl[rrb_pkg::CB_RM_EN];
        b2b = (DOUBLE_WIDTH != 0) || q.ctrl[rrb_pkg::CB_B2B];
        rd_word = q.mem[q.rp];
        wr_pat = is_skip(sw_word, q.pat1, q.pat2);
        rd_pat = is_skip(rd_word, q.pat1, q.pat2);
        do_del = rm_on && q.aw_v && wr_pat && q.cnt >= CW'(HI_WM) && (b2b || !q.del_last);
        do_wr = rm_on && q.aw_v && !do_del && q.cnt != CW'(DEPTH);
        do_rd = rm_on && RD_EN && q.cnt != '0;
        do_ins = do_rd && rd_pat && q.cnt <= CW'(LO_WM) && (b2b || !q.ins_last);
        pop = do_rd && !do_ins;
        if (do_wr)
        begin
            n.mem[q.wp] = sw_word;
            n.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop)
            n.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        n.cnt = q.cnt + CW'(do_wr) - CW'(pop);
        if (q.aw_v && wr_pat)
            n.del_last = do_del;
        if (do_rd && rd_pat)
            n.ins_last = do_ins;
        n.ins = do_ins;
        n.del = do_del;
        n.full = (n.cnt == CW'(DEPTH));
        n.empty = (n.cnt <= CW'(EMPTY_LVL));

        bw = rm_on ? rd_word : sw_word;
        bv = rm_on ? do_rd : q.aw_v;

        trig = q.ctrl[rrb_pkg::CB_TRIG] ? BO_REQ : q.lock;
        rise = trig && !q.trig_prev;
        n.trig_prev = trig;
        bo_on = BO_ALLOWED && q.ctrl[rrb_pkg::CB_BO_EN];
        if (rise && bo_on)
            n.bo_arm = 1'b1;
        lo_eff = q.shift ? q.held : bw[SW-1:0];
        n.out_v = bv;
        if (bv)
        begin
            n.bo_arm = 1'b0;
            if (bo_on && (q.bo_arm || rise) && lo_eff != q.bo_pat)
            begin
                // pad takes the low slot; in a shifted frame the held symbol is dropped
                n.out_data = {bw[SW-1:0], q.bo_pad};
                n.shift = 1'b1;
            end
            else if (q.shift)
                n.out_data = {bw[SW-1:0], q.held};
            else
                n.out_data = bw;
            n.held = bw[WW-1:SW];
        end
        if (!bo_on)
            n.shift = 1'b0;

        n.waitreq = 1'b1;
        if ((READ || WRITE) && q.waitreq)
            n.waitreq = 1'b0;
        if (READ && q.waitreq)
        begin
            n.rdata = '0;
            if (ADDRESS == rrb_pkg::OFS_CTRL)
                n.rdata[5:0] = q.ctrl;
            else if (ADDRESS == rrb_pkg::OFS_RMPAT1)
                n.rdata[WW-1:0] = q.pat1;
            else if (ADDRESS == rrb_pkg::OFS_RMPAT2)
                n.rdata[WW-1:0] = q.pat2;
            else if (ADDRESS == rrb_pkg::OFS_BOPAT)
                n.rdata = {6'h00, q.bo_pad, 6'h00, q.bo_pat};
            else if (ADDRESS == rrb_pkg::OFS_ALPAT)
                n.rdata[SW-1:0] = q.al_pat;
            else if (ADDRESS == rrb_pkg::OFS_STATUS)
            begin
                n.rdata[rrb_pkg::SB_LOCK] = q.lock;
                n.rdata[rrb_pkg::SB_FULL] = q.full;
                n.rdata[rrb_pkg::SB_EMPTY] = q.empty;
                n.rdata[rrb_pkg::SB_SHIFT] = q.shift;
                n.rdata[rrb_pkg::SB_SLIP +: LW] = q.slip;
                n.rdata[rrb_pkg::SB_CNT +: CW] = q.cnt;
            end
        end
        // a write lands on the edge where the master sees waitrequest low
        if (WRITE && !q.waitreq)
        begin
            if (ADDRESS == rrb_pkg::OFS_CTRL)
                n.ctrl = WRITEDATA[5:0];
            else if (ADDRESS == rrb_pkg::OFS_RMPAT1)
                n.pat1 = WRITEDATA[WW-1:0];
            else if (ADDRESS == rrb_pkg::OFS_RMPAT2)
                n.pat2 = WRITEDATA[WW-1:0];
            else if (ADDRESS == rrb_pkg::OFS_BOPAT)
            begin
                n.bo_pat = WRITEDATA[SW-1:0];
                n.bo_pad = WRITEDATA[rrb_pkg::BO_PAD_LSB +: SW];
            end
            else if (ADDRESS == rrb_pkg::OFS_ALPAT)
                n.al_pat = WRITEDATA[SW-1:0];
        end
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            q <= '0;
            q.waitreq <= 1'b1;
        end
        else
            q <= n;
    end

    assign READDATA      = q.rdata;
    assign WAITREQUEST   = q.waitreq;
    assign RX_DATA_OUT   = q.out_data;
    assign RX_DATA_VALID = q.out_v;
    assign RX_LOCK       = q.lock;
    assign RX_SLIP_COUNT = (SLIP_OUT_EN != 0) ? q.slip : '0;
    assign RM_FULL       = q.full;
    assign RM_EMPTY      = q.empty;
    assign RM_INSERTED   = q.ins;
    assign RM_DELETED    = q.del;
endmodule

/* File: sim/rrb_rx_post_align_asserts.sv */
/* port checker of the receive post-alignment block.
   assumes it is bound into every instance of the block. */
`timescale 1ns/1ps
module rrb_rx_post_align_chk (
    input wire logic       REF_CLK,       // clock
    input wire logic       RST,           // reset
    input wire logic       READ,          // bus read
    input wire logic       WRITE,         // bus write
    input wire logic       WAITREQUEST,   // bus stall
    input wire logic       RX_RAW_VALID,  // raw strobe
    input wire logic       BITSLIP,       // slip
    input wire logic       RD_EN,         // drain
    input wire logic       RX_LOCK,       // lock
    input wire logic [$clog2(rrb_pkg::WORD_W)-1:0] RX_SLIP_COUNT, // slips
    input wire logic       RM_FULL,       // full
    input wire logic       RM_EMPTY,      // empty
    input wire logic       RM_INSERTED,   // insert
    input wire logic       RM_DELETED     // delete
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    sequence s_req; (READ || WRITE) && WAITREQUEST; endsequence
    // six quiet samples cover the sync and framing stages ahead of the buffer
    sequence s_quiet; !RX_RAW_VALID [*6] ##0 RM_EMPTY; endsequence
    property p_wait_ans; s_req |=> !WAITREQUEST ##1 WAITREQUEST; endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("bus answer wrong");
    property p_slip_rng; RX_SLIP_COUNT < 5'h14; endproperty
    a_slip_rng: assert property (p_slip_rng) else $error("slip count range");
    property p_slip_lock; $rose(BITSLIP) |-> ##[1:3] !RX_LOCK; endproperty
    a_slip_lock: assert property (p_slip_lock) else $error("lock kept on slip");
    property p_ins_room; RM_INSERTED |-> !RM_FULL; endproperty
    a_ins_room: assert property (p_ins_room) else $error("insert when full");
    property p_del_room; RM_DELETED |-> !RM_EMPTY; endproperty
    a_del_room: assert property (p_del_room) else $error("delete when empty");
    property p_one_evt; !(RM_INSERTED && RM_DELETED); endproperty
    a_one_evt: assert property (p_one_evt) else $error("insert and delete");
    property p_full_hold; RM_FULL && !RD_EN |=> RM_FULL; endproperty
    a_full_hold: assert property (p_full_hold) else $error("full dropped");
    property p_empty_hold; s_quiet |=> RM_EMPTY; endproperty
    a_empty_hold: assert property (p_empty_hold) else $error("empty dropped");
endmodule
bind rrb_rx_post_align rrb_rx_post_align_chk i_rrb_rx_post_align_chk (.REF_CLK(REF_CLK), .RST(RST),
    .READ(READ), .WRITE(WRITE), .WAITREQUEST(WAITREQUEST), .RX_RAW_VALID(RX_RAW_VALID), .BITSLIP(BITSLIP),
    .RD_EN(RD_EN), .RX_LOCK(RX_LOCK), .RX_SLIP_COUNT(RX_SLIP_COUNT), .RM_FULL(RM_FULL), .RM_EMPTY(RM_EMPTY),
    .RM_INSERTED(RM_INSERTED), .RM_DELETED(RM_DELETED));

/* File: sim/rrb_fabric_sink.sv */
/* fabric sink model: drains words, raises the order request, counts pulses.
   assumes the block's clock and reset. */
`timescale 1ns/1ps
module rrb_fabric_sink (
    input  wire logic clk,     // clock
    input  wire logic rst,     // reset
    input  wire logic drain,   // take words
    input  wire logic slow,    // stall alternate cycles
    input  wire logic realign, // order request
    input  wire logic valid,   // word strobe
    input  wire logic ins,     // insert pulse
    input  wire logic del,     // delete pulse
    output logic      rd_en,   // drain
    output logic      bo_req,  // order request
    output int        n_words, // words
    output int        n_ins,   // inserts
    output int        n_del    // deletes
);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_en <= 1'b0;
            bo_req <= 1'b0;
            n_words <= 0;
            n_ins <= 0;
            n_del <= 0;
        end
        else
        begin
            rd_en <= drain && (!slow || !rd_en);
            bo_req <= realign;
            n_words <= n_words + int'(valid);
            n_ins <= n_ins + int'(ins);
            n_del <= n_del + int'(del);
        end
    end
endmodule

/* File: sim/rrb_rx_post_align_bench.sv */
/* bench of the receive post-alignment block.
   assumes a single-width and a double-width build of the block and the sink model. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t mismatch got %0h want %0h", $time, g, e); end end
module rrb_rx_post_align_bench;
    logic        clk = 0, rst = 1, rd = 0, wr = 0, vld = 0, slip = 0, drain = 0, slow = 0, realign = 0;
    logic [5:0]  adr = '0;
    logic [31:0] wd = '0, rdat, r;
    logic [19:0] raw = '0, dout, w;
    logic [19:0] dout2, w2;
    logic [4:0]  scnt;
    logic        wreq, dv, lock, full, empty, ins, del, rd_en, bo_req;
    int          fail_count = 0, n_checks = 0, cyc = 0, nw, ni, nd;
    always #20 clk = ~clk;
    rrb_rx_post_align i_rrb_rx_post_align (.REF_CLK(clk), .RST(rst), .ADDRESS(adr), .READ(rd), .WRITE(wr),
        .WRITEDATA(wd), .READDATA(rdat), .WAITREQUEST(wreq), .RX_RAW(raw), .RX_RAW_VALID(vld), .BITSLIP(slip),
        .BO_REQ(bo_req), .RD_EN(rd_en), .RX_DATA_OUT(dout), .RX_DATA_VALID(dv), .RX_LOCK(lock),
        .RX_SLIP_COUNT(scnt), .RM_FULL(full), .RM_EMPTY(empty), .RM_INSERTED(ins), .RM_DELETED(del));
    rrb_fabric_sink i_rrb_fabric_sink (.clk(clk), .rst(rst), .drain(drain), .slow(slow), .realign(realign),
        .valid(dv), .ins(ins), .del(del), .rd_en(rd_en), .bo_req(bo_req), .n_words(nw), .n_ins(ni), .n_del(nd));
    // double-width build shares the bus and stream; only its word is compared, for the swap control
    rrb_rx_post_align #(.DOUBLE_WIDTH(1), .CHAN_WIDTH(40)) i_rrb_rx_post_align_dw (.REF_CLK(clk), .RST(rst),
        .ADDRESS(adr), .READ(rd), .WRITE(wr), .WRITEDATA(wd), .READDATA(), .WAITREQUEST(), .RX_RAW(raw),
        .RX_RAW_VALID(vld), .BITSLIP(slip), .BO_REQ(bo_req), .RD_EN(rd_en), .RX_DATA_OUT(dout2),
        .RX_DATA_VALID(), .RX_LOCK(), .RX_SLIP_COUNT(), .RM_FULL(), .RM_EMPTY(), .RM_INSERTED(), .RM_DELETED());
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
        rd <= !we;
        wr <= we;
        adr <= a;
        wd <= d;
        @(posedge clk);
        while (wreq !== 1'b0)
            @(posedge clk);
        r = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic get();
        for (int k = 0; k < 40; k++)
        begin
            @(posedge clk);
            if (dv === 1'b1)
                break;
        end
        w = dout;
        w2 = dout2;
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        vld <= 1'b0;
        drain <= 1'b0;
        slow <= 1'b0;
        realign <= 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_regs();
        bus(0, rrb_pkg::OFS_CTRL, 32'h0);
        `CHK(r, 32'h0)
        bus(1, rrb_pkg::OFS_RMPAT2, 32'h83E83);
        bus(0, rrb_pkg::OFS_RMPAT2, 32'h0);
        `CHK(r, 32'h83E83)
        bus(0, 6'h3C, 32'h0);
        `CHK(r, 32'h0)
        $display("regs done");
    endtask
    task automatic t_pol();
        // swap bit must do nothing in a single-width build
        bus(1, rrb_pkg::OFS_CTRL, 32'h3);
        raw <= 20'h12345;
        vld <= 1'b1;
        repeat (4) get();
        `CHK(w, ~20'h12345)
        `CHK(w2, {~10'h345, ~10'h048})
        vld <= 1'b0;
        $display("polarity done");
    endtask
    task automatic t_slip();
        bus(1, rrb_pkg::OFS_CTRL, 32'h0);
        bus(1, rrb_pkg::OFS_ALPAT, 32'h345);
        raw <= 20'h12345;
        vld <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(lock, 1'b1)
        for (int i = 1; i <= 20; i++)
        begin
            slip <= 1'b1;
            @(posedge clk);
            slip <= 1'b0;
            repeat (3) @(posedge clk);
            `CHK(scnt, 5'(i % 20))
            if (i == 1)
                `CHK(lock, 1'b0)
        end
        repeat (8) @(posedge clk);
        `CHK(lock, 1'b1)
        vld <= 1'b0;
        $display("slip done");
    endtask
    task automatic t_fill();
        do_reset();
        bus(1, rrb_pkg::OFS_CTRL, 32'h4);
        `CHK(empty, 1'b1)
        raw <= 20'h0A5A5;
        vld <= 1'b1;
        repeat (24) @(posedge clk);
        vld <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK(full, 1'b1)
        bus(0, rrb_pkg::OFS_STATUS, 32'h0);
        `CHK(r[20:16], 5'h14)
        drain <= 1'b1;
        repeat (60) @(posedge clk);
        `CHK(nw, 32'h14)
        `CHK(empty, 1'b1)
        $display("fill done");
    endtask
    task automatic t_skip(input logic [19:0] p, input logic b2b);
        do_reset();
        bus(1, rrb_pkg::OFS_RMPAT1, 32'h7C17C); // skip group of five ones
        bus(1, rrb_pkg::OFS_RMPAT2, 32'h83E83); // skip group of five zeros
        bus(1, rrb_pkg::OFS_CTRL, b2b ? 32'hC : 32'h4);
        raw <= p;
        vld <= 1'b1;
        repeat (17) @(posedge clk);
        vld <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(nd, b2b ? 32'h3 : 32'h2)
        // with back-to-back on, an all-skip buffer at the low mark inserts forever, so no drain count
        if (!b2b)
        begin
            slow <= 1'b1;
            drain <= 1'b1;
            repeat (150) @(posedge clk);
            `CHK(ni, rrb_pkg::RM_LO_WM)
            `CHK(nw, 32'hF + ni)
        end
        $display("skip done");
    endtask
    task automatic t_bo(input logic by_lock);
        do_reset();
        bus(1, rrb_pkg::OFS_BOPAT, 32'h015A0123);
        bus(1, rrb_pkg::OFS_ALPAT, 32'h0CC);
        bus(1, rrb_pkg::OFS_CTRL, by_lock ? 32'h10 : 32'h30);
        raw <= {10'h123, 10'h0CC};
        vld <= 1'b1;
        // the lock edge comes a few words in, so the lock run starts watching at once
        if (!by_lock)
        begin
            repeat (6) @(posedge clk);
            realign <= 1'b1;
        end
        w = '0;
        for (int i = 0; i < 8 && w !== {10'h0CC, 10'h15A}; i++)
            get();
        `CHK(w, {10'h0CC, 10'h15A})
        get();
        `CHK(w, {10'h0CC, 10'h123})
        $display("order done");
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            finish_test();
        end
    end
    initial
    begin
        do_reset();
        t_regs();
        t_pol();
        t_slip();
        t_fill();
        t_skip(20'h7C17C, 1'b0);
        t_skip(20'h83E83, 1'b0);
        t_skip(20'h83E83, 1'b1);
        t_bo(1'b0);
        t_bo(1'b1);
        finish_test();
    end
endmodule
